// file: rtl/buck_switcher_config_regs.sv
/*
 * Configuration register bank for bucks one to four: output levels,
 * idle limits, range selects, operating modes and clock multiplier.
 * Assumes a simple synchronous register port driven by the serial
 * control front end, and reset inputs synchronous to clk_i.
 */
`default_nettype none

module buck_switcher_config_regs #(
   parameter int SEL_W = 2                                // Width of the power-up mode select.
) (
   // Clock and logic power-on reset.
   input  wire logic                  clk_i,
   input  wire logic                  rst_n_i,
   // Device resets, active low, synchronous levels.
   input  wire logic                  main_reset_n_i,
   input  wire logic                  power_off_reset_n_i,
   // Startup sequencer.
   input  wire logic                  startup_load_i,
   input  wire logic [SEL_W-1:0]      power_up_mode_select_i,
   // Register port.
   input  wire logic [5:0]            reg_addr_i,
   input  wire logic                  reg_wr_i,
   input  wire logic [23:0]           reg_wdata_i,
   input  wire logic                  reg_rd_i,
   output logic      [23:0]           reg_rdata_o,
   output logic                       reg_rvalid_o,
   output logic                       reg_hit_o,
   // Buck two levels.
   output logic      [4:0]            buck_two_normal_level_o,
   output logic      [4:0]            buck_two_scaling_level_o,
   output logic      [4:0]            buck_two_standby_level_o,
   output logic      [3:0]            buck_two_idle_max_level_o,
   output logic      [4:0]            buck_two_idle_min_level_o,
   output logic                       buck_two_range_select_o,
   // Buck three and four levels.
   output logic      [4:0]            buck_three_normal_level_o,
   output logic      [4:0]            buck_three_standby_level_o,
   output logic                       buck_three_range_select_o,
   output logic      [4:0]            buck_four_normal_level_o,
   output logic      [4:0]            buck_four_standby_level_o,
   output logic                       buck_four_range_select_o,
   // Buck one and two modes.
   output logic      [3:0]            buck_one_operating_mode_o,
   output logic                       buck_one_memory_hold_o,
   output logic                       buck_one_user_off_o,
   output logic      [1:0]            buck_one_scaling_speed_o,
   output logic                       dynamic_idle_enable_o,
   output logic      [3:0]            buck_two_operating_mode_o,
   output logic                       buck_two_memory_hold_o,
   output logic                       buck_two_user_off_o,
   output logic      [1:0]            buck_two_scaling_speed_o,
   // Shared switcher controls.
   output logic                       switcher_clock_multiplier_enable_o,
   output logic      [2:0]            switcher_clock_multiplier_factor_o,
   output logic                       current_limit_disable_o
);

   // ****************************************************************
   // Storage
   // ****************************************************************
   logic [23:0] levels_reg [3];     // Never-reset bits of registers 25, 26 and 27.
   logic [23:0] idle_reg;           // Buck two idle limits.
   logic [23:0] main_reg;           // Mode register bits reset by the main reset.
   logic [23:0] off_reg;            // Mode register bits cleared by the power-off reset.
   logic [23:0] rdata_reg;          // Registered read data.
   logic        rvalid_reg;         // Read answer strobe.
   logic [3:0]  start_one_mode;     // Startup mode for buck one.
   logic [3:0]  start_two_mode;     // Startup mode for buck two.
   logic [23:0] modes_image;        // Mode register as software sees it.
   logic [23:0] read_next;          // Read mux output.

   // Decodes a level register index from an address; three means none.
   function automatic logic [1:0] level_index(input logic [5:0] addr);
      case (addr)
         buck_cfg_pkg::ADDR_LEVELS2: level_index = 2'h0;
         buck_cfg_pkg::ADDR_LEVELS3: level_index = 2'h1;
         buck_cfg_pkg::ADDR_LEVELS4: level_index = 2'h2;
         default:                    level_index = 2'h3;
      endcase
   endfunction

   // True when a write to the mode register is under way.
   function automatic logic modes_write(input logic wr, input logic [5:0] addr);
      modes_write = wr && (addr == buck_cfg_pkg::ADDR_MODES);
   endfunction

   // ****************************************************************
   // Startup defaults
   // ****************************************************************
   buck_startup_defaults #(
      .SEL_W                  (SEL_W)
   ) u_startup (
      .power_up_mode_select_i (power_up_mode_select_i),
      .buck_one_mode_o        (start_one_mode),
      .buck_two_mode_o        (start_two_mode)
   );

   // ****************************************************************
   // Level registers
   // ****************************************************************

   // Never-reset level bits: only the logic power-on sets them, device resets do not.
   for (genvar g = 0; g < 3; g++) begin : g_levels
      always_ff @(posedge clk_i) begin
         if (!rst_n_i) begin
            levels_reg[g] <= buck_cfg_pkg::LEVEL_INIT;
         end else if (reg_wr_i && (level_index(reg_addr_i) == 2'(g))) begin
            // Unused bits are masked off so they keep reading zero.
            levels_reg[g] <= reg_wdata_i & buck_cfg_pkg::LEVEL_MASK;
         end
      end
   end

   // Idle limits of buck two, restored by the main reset.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || !main_reset_n_i) begin
         idle_reg <= buck_cfg_pkg::IDLE_RESET;
      end else if (reg_wr_i && (reg_addr_i == buck_cfg_pkg::ADDR_LEVELS2)) begin
         idle_reg <= reg_wdata_i & buck_cfg_pkg::IDLE_MASK;
      end
   end

   // ****************************************************************
   // Mode register
   // ****************************************************************

   // Main-reset bits; the startup load overrides a write in the same cycle.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || !main_reset_n_i) begin
         main_reg <= buck_cfg_pkg::MAIN_RESET;
      end else if (startup_load_i) begin
         main_reg[buck_cfg_pkg::MODE_ONE_LSB +: buck_cfg_pkg::MODE_W] <= start_one_mode;
         main_reg[buck_cfg_pkg::MODE_TWO_LSB +: buck_cfg_pkg::MODE_W] <= start_two_mode;
      end else if (modes_write(reg_wr_i, reg_addr_i)) begin
         main_reg <= reg_wdata_i & buck_cfg_pkg::MAIN_MASK;
      end
   end

   // Memory-hold and user-off bits, cleared by the power-off reset and logic power-on, not by the main reset.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i || !power_off_reset_n_i) begin
         off_reg <= 24'h000000;
      end else if (modes_write(reg_wr_i, reg_addr_i)) begin
         off_reg <= reg_wdata_i & buck_cfg_pkg::OFF_MASK;
      end
   end

   // ****************************************************************
   // Read path
   // ****************************************************************

   // Mode register image; bits 9 and 23 are outside both masks and read zero.
   assign modes_image = (main_reg & buck_cfg_pkg::MAIN_MASK) | (off_reg & buck_cfg_pkg::OFF_MASK);

   // Read mux; unmapped addresses answer zero.
   always_comb begin
      read_next = 24'h000000;
      case (reg_addr_i)
         buck_cfg_pkg::ADDR_LEVELS2: read_next = levels_reg[0] | (idle_reg & buck_cfg_pkg::IDLE_MASK);
         buck_cfg_pkg::ADDR_LEVELS3: read_next = levels_reg[1] & buck_cfg_pkg::LEVEL_MASK;
         buck_cfg_pkg::ADDR_LEVELS4: read_next = levels_reg[2] & buck_cfg_pkg::LEVEL_MASK;
         buck_cfg_pkg::ADDR_MODES:   read_next = modes_image;
         default:                    read_next = 24'h000000;
      endcase
   end

   // Read data is captured on the request and held until the next one.
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         rdata_reg  <= 24'h000000;
         rvalid_reg <= 1'b0;
      end else begin
         rvalid_reg <= reg_rd_i;
         if (reg_rd_i) begin
            rdata_reg <= read_next;
         end
      end
   end

   assign reg_rdata_o  = rdata_reg;
   assign reg_rvalid_o = rvalid_reg;
   assign reg_hit_o    = (level_index(reg_addr_i) != 2'h3) || (reg_addr_i == buck_cfg_pkg::ADDR_MODES);

   // ****************************************************************
   // Field outputs
   // ****************************************************************
   assign buck_two_normal_level_o            = levels_reg[0][4:0];
   assign buck_two_scaling_level_o           = levels_reg[0][9:5];
   assign buck_two_standby_level_o           = levels_reg[0][14:10];
   assign buck_two_idle_max_level_o          = idle_reg[18:15];
   assign buck_two_idle_min_level_o          = {1'b0, idle_reg[22:19]};
   assign buck_two_range_select_o            = levels_reg[0][23];
   assign buck_three_normal_level_o          = levels_reg[1][4:0];
   assign buck_three_standby_level_o         = levels_reg[1][14:10];
   assign buck_three_range_select_o          = levels_reg[1][23];
   assign buck_four_normal_level_o           = levels_reg[2][4:0];
   assign buck_four_standby_level_o          = levels_reg[2][14:10];
   assign buck_four_range_select_o           = levels_reg[2][23];
   assign buck_one_operating_mode_o          = main_reg[3:0];
   assign buck_one_memory_hold_o             = off_reg[4];
   assign buck_one_user_off_o                = off_reg[5];
   assign buck_one_scaling_speed_o           = main_reg[7:6];
   assign dynamic_idle_enable_o              = main_reg[8];
   assign buck_two_operating_mode_o          = main_reg[13:10];
   assign buck_two_memory_hold_o             = off_reg[14];
   assign buck_two_user_off_o                = off_reg[15];
   assign buck_two_scaling_speed_o           = main_reg[17:16];
   assign switcher_clock_multiplier_enable_o = main_reg[18];
   assign switcher_clock_multiplier_factor_o = main_reg[21:19];
   assign current_limit_disable_o            = main_reg[22];

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);

   // Level bits of registers 25 and 26 survive a main or power-off reset.
   a_levels_keep_reset: assert property (
      (!main_reset_n_i || !power_off_reset_n_i) && !reg_wr_i |=> $stable(levels_reg[0]) && $stable(levels_reg[1])
   ) else $error("level register changed on device reset");

   // Main reset restores the idle limits.
   a_idle_main_reset: assert property (
      !main_reset_n_i |=> buck_two_idle_max_level_o == 4'hA && buck_two_idle_min_level_o == 5'h08
   ) else $error("idle limits not restored by main reset");

   // Implied top bit of idle minimum.
   a_idle_min_top: assert property (
      buck_two_idle_min_level_o[4] == 1'b0
   ) else $error("idle minimum top bit set");

   // Unused bits of registers 26 and 27 read zero.
   a_unused_read_zero: assert property (
      reg_rd_i && (reg_addr_i == buck_cfg_pkg::ADDR_LEVELS3 || reg_addr_i == buck_cfg_pkg::ADDR_LEVELS4)
      |=> reg_rdata_o[22:15] == 8'h00
   ) else $error("unused level bits read nonzero");

   // Mode register write, one quiet cycle, then read returns data under mask, bits 9 and 23 zero.
   a_modes_write_read: assert property (
      modes_write(reg_wr_i, reg_addr_i) && main_reset_n_i && power_off_reset_n_i && !startup_load_i
      ##1 !reg_wr_i && main_reset_n_i && power_off_reset_n_i && !startup_load_i
      ##1 reg_rd_i && reg_addr_i == buck_cfg_pkg::ADDR_MODES && !reg_wr_i
      |=> reg_rdata_o == ($past(reg_wdata_i, 3) & 24'h7FFDFF)
   ) else $error("mode register readback wrong");

   // Main reset gives the documented mode image.
   a_modes_main_reset: assert property (
      !main_reset_n_i && power_off_reset_n_i |=> buck_one_operating_mode_o == 4'hA
      && buck_two_operating_mode_o == 4'hA && buck_one_scaling_speed_o == 2'h1
      && buck_two_scaling_speed_o == 2'h1 && !dynamic_idle_enable_o
   ) else $error("mode fields wrong after main reset");

   // Multiplier and current limit after main reset.
   a_pll_main_reset: assert property (
      !main_reset_n_i |=> !switcher_clock_multiplier_enable_o
      && switcher_clock_multiplier_factor_o == 3'h4 && !current_limit_disable_o
   ) else $error("multiplier fields wrong after main reset");

   // Memory hold and user off clear on power-off reset but not on main reset alone.
   a_off_bits_reset: assert property (
      !power_off_reset_n_i |=> !buck_one_memory_hold_o && !buck_one_user_off_o
      && !buck_two_memory_hold_o && !buck_two_user_off_o
   ) else $error("hold or user-off bit set after power-off reset");

   a_off_bits_main_keep: assert property (
      !main_reset_n_i && power_off_reset_n_i && !reg_wr_i |=> $stable(off_reg)
   ) else $error("hold bits disturbed by main reset");

   // Startup load applies mode select defaults.
   a_startup_modes: assert property (
      startup_load_i && main_reset_n_i |=> buck_one_operating_mode_o == $past(start_one_mode)
      && buck_two_operating_mode_o == $past(start_two_mode)
   ) else $error("startup modes not loaded");

   a_startup_pwm: assert property (
      startup_load_i && main_reset_n_i && power_up_mode_select_i[SEL_W-1] |=> buck_two_operating_mode_o == 4'hA
   ) else $error("enabled buck two not pulse-width modulation");

   c_modes_write:   cover property (modes_write(reg_wr_i, reg_addr_i) ##2 reg_rd_i);
   c_main_reset:    cover property (!main_reset_n_i ##1 main_reset_n_i);
   c_startup_load:  cover property (startup_load_i && |power_up_mode_select_i);
   c_level_write:   cover property (reg_wr_i && reg_addr_i == buck_cfg_pkg::ADDR_LEVELS2 ##1 reg_rd_i);

endmodule // buck_switcher_config_regs

`default_nettype wire

// file: include/buck_cfg_pkg.sv
/*
 * Constants for the buck switcher configuration register bank: register
 * addresses, writable masks, reset values and operating mode codes.
 * Assumes the registers are 24 bits wide and addressed by a 6-bit index.
 */
// Notes on behaviour
// - Buck two normal level, bits 0-4, never reset.
// - Buck two scaling level, bits 5-9, never reset.
// - Buck two standby level, bits 10-14, never reset.
// - Idle max bits 15-18, main reset 1010.
// - Idle min bits 19-22, main reset 1000.
// - Buck two range select bit 23, never reset.
// - Buck three level and spare bits, never reset.
// - Buck three standby level bits 10-14, unreset.
// - Register 26 bits 15-22 zero, bit 23 range.
// - Buck four level and spare bits, never reset.
// - Buck four standby level bits 10-14, unreset.
// - Register 27 bits 15-22 zero, bit 23 range.
// - Buck one mode main reset; hold/off on power-off.
// - Buck one speed resets 01; idle enable clears.
// - Buck two mode main reset; hold/off on power-off.
// - Buck two speed field resets to 01.
// - Multiplier enable clears; factor resets to 100.
// - Current limit disable clears; bits 9,23 zero.
// - Startup sequencer loads modes from mode select.
// - Enabled buck defaults to plain pulse-width modulation.

`default_nettype none

package buck_cfg_pkg;

   // ****************************************************************
   // Register addressing
   // ****************************************************************
   localparam int          ADDR_W       = 6;       // Width of the register index.
   localparam int          DATA_W       = 24;      // Width of every register.
   localparam logic [5:0]  ADDR_LEVELS2 = 6'h19;   // Buck two levels.
   localparam logic [5:0]  ADDR_LEVELS3 = 6'h1A;   // Buck three levels.
   localparam logic [5:0]  ADDR_LEVELS4 = 6'h1B;   // Buck four levels.
   localparam logic [5:0]  ADDR_MODES   = 6'h1C;   // Modes and clock multiplier.

   // ****************************************************************
   // Writable masks
   // ****************************************************************
   localparam logic [23:0] LEVEL_MASK   = 24'h807FFF;  // Bits never reset in level registers.
   localparam logic [23:0] IDLE_MASK    = 24'h7F8000;  // Buck two idle limits.
   localparam logic [23:0] MAIN_MASK    = 24'h7F3DCF;  // Mode register bits on main reset.
   localparam logic [23:0] OFF_MASK     = 24'h00C030;  // Mode register bits on power-off reset.

   // ****************************************************************
   // Reset values
   // ****************************************************************
   localparam logic [23:0] IDLE_RESET   = 24'h450000;  // Max 1010 at 15, min 1000 at 19.
   localparam logic [23:0] MAIN_RESET   = 24'h21284A;  // Mode register main reset image, both modes 1010.
   localparam logic [23:0] LEVEL_INIT   = 24'h000000;  // Power-on value of never-reset bits.

   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int          MODE_ONE_LSB = 0;       // Buck one operating mode.
   localparam int          MODE_TWO_LSB = 10;      // Buck two operating mode.
   localparam int          MODE_W       = 4;       // Operating mode width.

   // ****************************************************************
   // Operating mode codes
   // ****************************************************************
   localparam logic [3:0]  MODE_PWM     = 4'hA;    // Pulse-width modulation, no skipping.
   localparam logic [3:0]  MODE_OFF     = 4'h0;    // Switcher disabled.

endpackage : buck_cfg_pkg

`default_nettype wire

// file: rtl/buck_startup_defaults.sv
/*
 * Startup defaults for the operating mode fields of bucks one and two,
 * decoded from the power-up mode select inputs.
 * Assumes the mode select inputs are stable while the startup load strobe is high.
 */
`default_nettype none

module buck_startup_defaults #(
   parameter int SEL_W = 2                            // Width of the power-up mode select.
) (
   // Mode select.
   input  wire logic [SEL_W-1:0] power_up_mode_select_i,
   // Default operating modes.
   output logic      [3:0]       buck_one_mode_o,
   output logic      [3:0]       buck_two_mode_o
);

   // ****************************************************************
   // Decode
   // ****************************************************************

   // Picks the mode code for a switcher from its enable.
   function automatic logic [3:0] mode_for(input logic enabled);
      mode_for = enabled ? buck_cfg_pkg::MODE_PWM : buck_cfg_pkg::MODE_OFF;
   endfunction

   // Buck one runs under any nonzero selection, buck two under the top select bit.
   always_comb begin
      buck_one_mode_o = mode_for(|power_up_mode_select_i);
      buck_two_mode_o = mode_for(power_up_mode_select_i[SEL_W-1]);
   end

endmodule // buck_startup_defaults

`default_nettype wire

// file: bench/host_model.sv
/*
 * Host model: issues whole-word reads and writes on the bank's register port.
 * Assumes one clock; it changes its requests only at the falling edge.
 */
`default_nettype none
module host_model (
   // Clock.
   input  wire logic        clk_i,
   // Register port towards the bank.
   output logic      [5:0]  reg_addr_o,
   output logic             reg_wr_o,
   output logic      [23:0] reg_wdata_o,
   output logic             reg_rd_o,
   input  wire logic [23:0] reg_rdata_i,
   input  wire logic        reg_rvalid_i,
   input  wire logic        reg_hit_i
);
   timeunit 1ns;
   timeprecision 1ns;
   // Idle port at time zero.
   initial begin
      reg_addr_o = 6'h00;
      reg_wr_o = 1'b0;
      reg_wdata_o = 24'h000000;
      reg_rd_o = 1'b0;
   end
   // Write one word; the strobe covers exactly one rising edge.
   task automatic write(input logic [5:0] a, input logic [23:0] d);
      @(negedge clk_i);
      reg_addr_o = a;
      reg_wdata_o = d;
      reg_wr_o = 1'b1;
      @(negedge clk_i);
      reg_wr_o = 1'b0;
      reg_wdata_o = ~d; // Stale data is not left on the lines.
   endtask
   // Read one word; the answer is taken in the cycle after the strobe.
   task automatic read(input logic [5:0] a, output logic [23:0] d, output logic v, output logic h);
      @(negedge clk_i);
      reg_addr_o = a;
      reg_rd_o = 1'b1;
      @(negedge clk_i);
      reg_rd_o = 1'b0;
      d = reg_rdata_i;
      v = reg_rvalid_i;
      h = reg_hit_i;
   endtask
endmodule // host_model
`default_nettype wire

// file: bench/testbench.sv
/*
 * Self-checking bench for the buck switcher configuration bank.
 * Assumes the host model drives the register port; resets and startup load come from here.
 */
`default_nettype none
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin failures++; $display("FAIL t=%0t got=%h exp=%h", $time, a, b); end end
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_i, rst_n_i, main_n, off_n, load;   // Clock, resets and startup load.
   logic [1:0]  sel;                                   // Power-up mode select.
   logic [5:0]  addr;                                  // Register port from the host.
   logic        wr, rd, rvalid, hit;
   logic [23:0] wdata, rdata;
   logic [3:0]  m1, m2;                                // Operating mode outputs.
   logic [4:0]  idle_min;                              // Idle minimum with implied top bit.
   wire  [23:0] o25, o26, o27, o28;                    // Field outputs gathered in register layout.
   int          failures = 0, checks_done = 0, cycles = 0;
   buck_switcher_config_regs dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .main_reset_n_i(main_n),
      .power_off_reset_n_i(off_n), .startup_load_i(load), .power_up_mode_select_i(sel),
      .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd), .reg_rdata_o(rdata),
      .reg_rvalid_o(rvalid), .reg_hit_o(hit), .buck_two_normal_level_o(o25[4:0]),
      .buck_two_scaling_level_o(o25[9:5]), .buck_two_standby_level_o(o25[14:10]),
      .buck_two_idle_max_level_o(o25[18:15]), .buck_two_idle_min_level_o(idle_min),
      .buck_two_range_select_o(o25[23]), .buck_three_normal_level_o(o26[4:0]),
      .buck_three_standby_level_o(o26[14:10]), .buck_three_range_select_o(o26[23]),
      .buck_four_normal_level_o(o27[4:0]), .buck_four_standby_level_o(o27[14:10]),
      .buck_four_range_select_o(o27[23]), .buck_one_operating_mode_o(m1), .buck_one_memory_hold_o(o28[4]),
      .buck_one_user_off_o(o28[5]), .buck_one_scaling_speed_o(o28[7:6]), .dynamic_idle_enable_o(o28[8]),
      .buck_two_operating_mode_o(m2), .buck_two_memory_hold_o(o28[14]), .buck_two_user_off_o(o28[15]),
      .buck_two_scaling_speed_o(o28[17:16]), .switcher_clock_multiplier_enable_o(o28[18]),
      .switcher_clock_multiplier_factor_o(o28[21:19]), .current_limit_disable_o(o28[22]));
   host_model host (.clk_i(clk_i), .reg_addr_o(addr), .reg_wr_o(wr), .reg_wdata_o(wdata),
      .reg_rd_o(rd), .reg_rdata_i(rdata), .reg_rvalid_i(rvalid), .reg_hit_i(hit));
   // Bits with no field output of their own read as zero in the gathered images.
   assign o25[22:19] = idle_min[3:0];
   assign o26[9:5]   = 5'h00;
   assign o26[22:15] = 8'h00;
   assign o27[9:5]   = 5'h00;
   assign o27[22:15] = 8'h00;
   assign o28[3:0]   = m1;
   assign o28[9]     = 1'b0;
   assign o28[13:10] = m2;
   assign o28[23]    = 1'b0;
   // 20 MHz clock.
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end
   // Cuts a hang short well beyond the expected run length.
   always @(posedge clk_i) begin
      cycles++;
      if (cycles == 5000) begin
         failures++;
         final_report();
      end
   end
   // Prints the counts and the verdict, then ends the run.
   task automatic final_report();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Reads one register and compares word, valid and decode hit.
   task automatic rd_chk(input logic [5:0] a, input logic [23:0] e, input logic eh);
      logic [23:0] d;
      logic        v, h;
      host.read(a, d, v, h);
      `CHK(v, 1'b1)
      `CHK(h, eh)
      `CHK(d, e)
   endtask
   // Compares the field outputs against register images; buck three and four share one image.
   task automatic fields_chk(input logic [23:0] e25, input logic [23:0] e26, input logic [23:0] e28);
      `CHK(o25, e25)
      `CHK(o26, e26)
      `CHK(o27, e26)
      `CHK(o28, e28)
   endtask
   // Pulses one active-low device reset for one edge.
   task automatic pulse(input bit main);
      @(negedge clk_i);
      if (main) main_n = 1'b0;
      else off_n = 1'b0;
      @(negedge clk_i);
      main_n = 1'b1;
      off_n = 1'b1;
   endtask
   // Main sequence.
   initial begin
      rst_n_i = 1'b0;
      main_n = 1'b1;
      off_n = 1'b1;
      load = 1'b0;
      sel = 2'h0;
      repeat (12) @(negedge clk_i);
      rst_n_i = 1'b1;
      rd_chk(6'h19, 24'h450000, 1'b1);
      rd_chk(6'h1C, 24'h21284A, 1'b1);
      $display("test reset_values done");
      for (int i = 0; i < 4; i++) host.write(6'(6'h19 + i), 24'hFFFFFF);
      rd_chk(6'h19, 24'hFFFFFF, 1'b1);
      rd_chk(6'h1A, 24'h807FFF, 1'b1);
      rd_chk(6'h1B, 24'h807FFF, 1'b1);
      rd_chk(6'h1C, 24'h7FFDFF, 1'b1);
      `CHK(idle_min, 5'h0F)
      fields_chk(24'hFFFFFF, 24'h807C1F, 24'h7FFDFF);
      $display("test write_all_ones done");
      pulse(1'b1);
      rd_chk(6'h19, 24'hC57FFF, 1'b1);
      rd_chk(6'h1A, 24'h807FFF, 1'b1);
      rd_chk(6'h1B, 24'h807FFF, 1'b1);
      rd_chk(6'h1C, 24'h21E87A, 1'b1);
      pulse(1'b0);
      rd_chk(6'h1C, 24'h21284A, 1'b1);
      rd_chk(6'h19, 24'hC57FFF, 1'b1);
      fields_chk(24'hC57FFF, 24'h807C1F, 24'h21284A);
      host.write(6'h1C, 24'h835A5A);
      rd_chk(6'h1C, 24'h03585A, 1'b1);
      $display("test device_resets done");
      host.write(6'h18, 24'hFFFFFF);
      rd_chk(6'h18, 24'h000000, 1'b0);
      rd_chk(6'h1D, 24'h000000, 1'b0);
      $display("test unmapped done");
      for (int s = 0; s < 4; s++) begin
         @(negedge clk_i);
         sel = 2'(s);
         load = 1'b1;
         @(negedge clk_i);
         load = 1'b0;
         `CHK(m1, (s != 0) ? 4'hA : 4'h0)
         `CHK(m2, sel[1] ? 4'hA : 4'h0)
      end
      @(negedge clk_i);
      sel = 2'h0;
      load = 1'b1;
      main_n = 1'b0; // The main reset must win over the startup load.
      @(negedge clk_i);
      load = 1'b0;
      main_n = 1'b1;
      `CHK(m1, 4'hA)
      `CHK(m2, 4'hA)
      $display("test startup_load done");
      final_report();
   end
endmodule // testbench
`default_nettype wire
